/* logic/crc_checker_and_mode_control.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------------
// CRC checker, generator gap pacing, software reset and mode control
// ------------------------------------------------------------------------
module crc_checker_and_mode_control
  import crc_check_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Packet-end strobes from the three receive paths (same clock)
  input  wire logic              copper_pkt_end,
  input  wire logic              copper_crc_bad,
  input  wire logic              sgmii_pkt_end,
  input  wire logic              sgmii_crc_bad,
  input  wire logic              qsgmii_pkt_end,
  input  wire logic              qsgmii_crc_bad,
  // Mode strap pins, asynchronous to the core clock
  input  wire logic [2:0]        mode_strap,
  // Generator handshake
  input  wire logic              gen_frame_done,
  output logic                   gen_gap_open,
  output logic      [7:0]        inter_frame_gap,
  // Effective state
  output logic      [2:0]        checker_source,
  output logic      [2:0]        active_mode,
  output media_type              active_media,
  output logic                   state_machine_reset,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction : reg_index

  function automatic logic word_ok(input logic [ADDR_W-1:0] a);
    word_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == 2'b00);
  endfunction : word_ok

  function automatic media_type decode_mode(input logic [2:0] m,
                                            input logic       auto_bit);
    unique case (m)
      MODE_Q_COPPER: decode_mode = MEDIA_Q_COP;
      MODE_S_COPPER: decode_mode = MEDIA_S_COP;
      MODE_Q_1000X:  decode_mode = MEDIA_Q_1000X;
      MODE_Q_100FX:  decode_mode = auto_bit ? MEDIA_Q_AUTO : MEDIA_Q_FX;
      default:       decode_mode = MEDIA_NONE;
    endcase
  endfunction : decode_mode

  // ----------------------------------------------------------------------
  // Strap synchroniser and register state
  // ----------------------------------------------------------------------
  logic [2:0]  strap_meta_reg;
  logic [2:0]  strap_sync_reg;
  logic        strap_meta_vld_reg;
  logic        strap_sync_vld_reg;
  logic        strap_loaded_reg, strap_loaded_next;
  logic [2:0]  src_reg,          src_next;
  logic [7:0]  gap_reg,          gap_next;
  logic [2:0]  mode_reg,         mode_next;
  logic [2:0]  act_mode_reg,     act_mode_next;
  logic        act_auto_reg,     act_auto_next;
  logic [10:0] gen_rsvd_reg,     gen_rsvd_next;
  logic        clr_pulse_reg,    clr_pulse_next;
  logic [1:0]  srst_cnt_reg,     srst_cnt_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_en_reg,   irq_en_next;
  logic [31:0] rdata_reg,        rdata_next;

  logic        wr_access;
  logic        rd_access;
  logic [7:0]  idx;
  logic        mapped;
  logic        srst_active;
  logic        pkt_end;
  logic        crc_bad;
  logic [7:0]  pkt_count;
  logic [7:0]  err_count;
  logic        pkt_max;
  logic        err_max;
  logic        counters_clr;

  // Strap pins pass two flops before use; the valid flags stop the
  // load from latching the synchroniser's reset value instead of a pin
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strap_meta_reg     <= MODE_Q_COPPER;
      strap_sync_reg     <= MODE_Q_COPPER;
      strap_meta_vld_reg <= 1'b0;
      strap_sync_vld_reg <= 1'b0;
    end else if (ce) begin
      strap_meta_reg     <= mode_strap;
      strap_sync_reg     <= strap_meta_reg;
      strap_meta_vld_reg <= 1'b1;
      strap_sync_vld_reg <= strap_meta_vld_reg;
    end
  end

  assign idx       = reg_index(paddr);
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign mapped    = word_ok(paddr) &&
                     (idx >= IDX_COUNTS) && (idx <= IDX_IRQ_CLEAR);
  assign srst_active = (srst_cnt_reg != 2'h0);

  // ----------------------------------------------------------------------
  // Receive path select and counters
  // ----------------------------------------------------------------------
  // source select
  always_comb begin
    unique case (src_reg)
      SRC_COPPER: begin
        pkt_end = copper_pkt_end;
        crc_bad = copper_crc_bad;
      end
      SRC_SGMII: begin
        pkt_end = sgmii_pkt_end;
        crc_bad = sgmii_crc_bad;
      end
      SRC_QSGMII: begin
        pkt_end = qsgmii_pkt_end;
        crc_bad = qsgmii_crc_bad;
      end
      default: begin
        pkt_end = 1'b0;
        crc_bad = 1'b0;
      end
    endcase
  end

  // clear pulse; source 000 also holds the checker in reset
  assign counters_clr = clr_pulse_reg || (src_reg == SRC_OFF);

  sat_counter u_pkt_count (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .clr      (counters_clr),
    .inc      (pkt_end),
    .count    (pkt_count),
    .at_max   (pkt_max)
  );

  sat_counter u_err_count (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .clr      (counters_clr),
    .inc      (pkt_end && crc_bad),
    .count    (err_count),
    .at_max   (err_max)
  );

  // ----------------------------------------------------------------------
  // Register file next state
  // ----------------------------------------------------------------------
  always_comb begin
    strap_loaded_next = strap_loaded_reg || strap_sync_vld_reg;
    src_next       = src_reg;
    gap_next       = gap_reg;
    mode_next      = mode_reg;
    act_mode_next  = act_mode_reg;
    act_auto_next  = act_auto_reg;
    gen_rsvd_next  = gen_rsvd_reg;
    clr_pulse_next = 1'b0;
    srst_cnt_next  = srst_active ? srst_cnt_reg - 2'h1 : srst_cnt_reg;
    irq_en_next    = irq_en_reg;
    irq_stat_next  = irq_stat_reg;
    rdata_next     = rdata_reg;
    if (!strap_loaded_reg && strap_sync_vld_reg) begin
      mode_next     = strap_sync_reg;
      act_mode_next = strap_sync_reg;
    end
    if (wr_access && mapped) begin
      unique case (idx)
        IDX_CHECKER: begin
          src_next       = pwdata[2:0];
          clr_pulse_next = pwdata[CLR_BIT];
        end
        IDX_GAP:        gap_next = pwdata[7:0];
        IDX_GENERAL: begin
          mode_next     = pwdata[2:0];
          gen_rsvd_next = pwdata[14:4];
          if (pwdata[SRST_BIT]) begin
            srst_cnt_next = SRST_CYCLES;
          end
        end
        IDX_IRQ_ENABLE: irq_en_next = pwdata[IRQ_W-1:0];
        IDX_IRQ_CLEAR:  irq_stat_next = irq_stat_reg & ~pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (srst_cnt_reg == 2'h1) begin
      act_mode_next = mode_reg;
      act_auto_next = gen_rsvd_reg[MEDIA_BIT-4];
    end
    // Set wins over clear
    if (pkt_end) begin
      irq_stat_next[IRQ_PKT] = 1'b1;
    end
    if (pkt_end && crc_bad) begin
      irq_stat_next[IRQ_CRC] = 1'b1;
    end
    if (pkt_max || err_max) begin
      irq_stat_next[IRQ_SAT] = 1'b1;
    end
    // Read data is captured in setup so it stands for the access cycle
    if (psel && !penable && !pwrite) begin
      rdata_next = 32'h0000_0000;
      unique case (reg_index(paddr))
        IDX_COUNTS:     rdata_next[15:0] = {pkt_count, err_count};
        IDX_CHECKER:    rdata_next[2:0]  = src_reg;
        IDX_GAP:        rdata_next[7:0]  = gap_reg;
        IDX_GENERAL:    rdata_next[15:0] = {srst_active, gen_rsvd_reg,
                                            1'b0, mode_reg};
        IDX_IRQ_STATUS: rdata_next[IRQ_W-1:0] = irq_stat_reg;
        IDX_IRQ_ENABLE: rdata_next[IRQ_W-1:0] = irq_en_reg;
        default: ;
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strap_loaded_reg <= 1'b0;
      src_reg       <= SRC_OFF;
      gap_reg       <= GAP_RESET;
      mode_reg      <= MODE_Q_COPPER;
      act_mode_reg  <= MODE_Q_COPPER;
      act_auto_reg  <= 1'b0;
      gen_rsvd_reg  <= GEN_RSVD_RESET;
      clr_pulse_reg <= 1'b0;
      srst_cnt_reg  <= 2'h0;
      irq_stat_reg  <= '0;
      irq_en_reg    <= '0;
      rdata_reg     <= 32'h0000_0000;
    end else if (ce) begin
      strap_loaded_reg <= strap_loaded_next;
      src_reg       <= src_next;
      gap_reg       <= gap_next;
      mode_reg      <= mode_next;
      act_mode_reg  <= act_mode_next;
      act_auto_reg  <= act_auto_next;
      gen_rsvd_reg  <= gen_rsvd_next;
      clr_pulse_reg <= clr_pulse_next;
      srst_cnt_reg  <= srst_cnt_next;
      irq_stat_reg  <= irq_stat_next;
      irq_en_reg    <= irq_en_next;
      rdata_reg     <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Generator gap pacing
  // ----------------------------------------------------------------------
  gap_state_type gap_state_reg, gap_state_next;
  logic [8:0]    gap_cnt_reg,   gap_cnt_next;

  // gap of value plus one bytes; the software reset aborts a gap
  always_comb begin
    gap_state_next = gap_state_reg;
    gap_cnt_next   = gap_cnt_reg;
    unique case (gap_state_reg)
      GAP_IDLE: begin
        if (gen_frame_done) begin
          gap_cnt_next   = {1'b0, gap_reg} + GAP_ONE;
          gap_state_next = GAP_WAIT;
        end
      end
      GAP_WAIT: begin
        gap_cnt_next = gap_cnt_reg - GAP_ONE;
        if (gap_cnt_reg == GAP_ONE) begin
          gap_state_next = GAP_DONE;
        end
      end
      GAP_DONE: gap_state_next = GAP_IDLE;
      default:  gap_state_next = GAP_IDLE;
    endcase
    if (srst_active) begin
      gap_state_next = GAP_IDLE;
      gap_cnt_next   = 9'h000;
    end
  end

  // Gap state storage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_state_reg <= GAP_IDLE;
      gap_cnt_reg   <= 9'h000;
    end else if (ce) begin
      gap_state_reg <= gap_state_next;
      gap_cnt_reg   <= gap_cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign gen_gap_open        = (gap_state_reg == GAP_DONE);
  assign inter_frame_gap     = gap_reg;
  assign checker_source      = src_reg;
  assign active_mode         = act_mode_reg;
  assign active_media        = decode_mode(act_mode_reg, act_auto_reg);
  assign state_machine_reset = srst_active;
  assign irq                 = |(irq_stat_reg & irq_en_reg);
  assign pready              = 1'b1;
  assign pslverr             = psel && penable && !mapped;
  assign prdata              = rdata_reg;

endmodule : crc_checker_and_mode_control

/* include/crc_check_pkg.sv */
// Summary of operation
// - Eight-bit CRC error count starts at zero and saturates at its maximum.
// - Writing one to counter clear zeroes both counts; bit self-clears.
// - Source field: 000 off/reset, 010 copper, 100 SGMII, 110 QSGMII.
// - Generator gap is programmed value plus one bytes; resets to eleven.
// - Software reset bit resets state machines at once, then self-clears.
// - New mode value takes effect only after a software reset.
// - Hardware reset loads the mode field from the strap inputs.
// - Mode 000 QSGMII-copper, 001 SGMII-copper, 010 QSGMII-1000BASE-X.
// - Mode 011 is QSGMII-100BASE-FX, or auto media when bit six set.
// - Eight-bit packet count in upper byte, starts at zero, saturates.
package crc_check_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses are four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IDX_COUNTS     = 8'h11;
  localparam logic [7:0]  IDX_CHECKER    = 8'h12;
  localparam logic [7:0]  IDX_GAP        = 8'h13;
  localparam logic [7:0]  IDX_GENERAL    = 8'h14;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'h15;
  localparam logic [7:0]  IDX_IRQ_ENABLE = 8'h16;
  localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'h17;
  localparam int          ADDR_W         = 12;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          CLR_BIT        = 4;
  localparam int          SRST_BIT       = 15;
  localparam int          MEDIA_BIT      = 6;
  localparam logic [7:0]  GAP_RESET      = 8'h0b;
  localparam logic [7:0]  COUNT_MAX      = 8'hff;
  localparam logic [7:0]  GAP_CNT_ZERO   = 8'h00;
  localparam logic [8:0]  GAP_ONE        = 9'h001;
  localparam logic [10:0] GEN_RSVD_RESET = 11'h020;  // Bit 9 set, bit 6 clear
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_PKT        = 0;
  localparam int          IRQ_CRC        = 1;
  localparam int          IRQ_SAT        = 2;
  localparam int          SRST_CYCLES_W  = 2;
  localparam logic [1:0]  SRST_CYCLES    = 2'h3;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  localparam logic [2:0]  SRC_OFF        = 3'h0;
  localparam logic [2:0]  SRC_COPPER     = 3'h2;
  localparam logic [2:0]  SRC_SGMII      = 3'h4;
  localparam logic [2:0]  SRC_QSGMII     = 3'h6;

  localparam logic [2:0]  MODE_Q_COPPER  = 3'h0;
  localparam logic [2:0]  MODE_S_COPPER  = 3'h1;
  localparam logic [2:0]  MODE_Q_1000X   = 3'h2;
  localparam logic [2:0]  MODE_Q_100FX   = 3'h3;

  typedef enum logic [2:0] {
    MEDIA_NONE    = 3'h0,
    MEDIA_Q_COP   = 3'h1,
    MEDIA_S_COP   = 3'h2,
    MEDIA_Q_1000X = 3'h3,
    MEDIA_Q_FX    = 3'h4,
    MEDIA_Q_AUTO  = 3'h5
  } media_type;

  typedef enum logic [1:0] {
    GAP_IDLE = 2'b00,
    GAP_WAIT = 2'b01,
    GAP_DONE = 2'b11
  } gap_state_type;

endpackage : crc_check_pkg

/* logic/sat_counter.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------------
// Saturating eight-bit counter with synchronous clear
// ------------------------------------------------------------------------
module sat_counter
  import crc_check_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       inc,
  output logic [7:0]      count,
  output logic            at_max
);

  logic [7:0] count_reg;
  logic [7:0] count_next;

  // Clear has priority; holds at max rather than wrapping
  always_comb begin
    count_next = count_reg;
    if (clr) begin
      count_next = GAP_CNT_ZERO;
    end else if (inc && count_reg != COUNT_MAX) begin
      count_next = count_reg + 8'h01;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= GAP_CNT_ZERO;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  assign count  = count_reg;
  assign at_max = (count_reg == COUNT_MAX);

endmodule : sat_counter

/* test/crc_check_props.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module crc_check_props
  import crc_check_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              gen_frame_done,
  input wire logic              gen_gap_open,
  input wire logic [7:0]        inter_frame_gap,
  input wire logic [2:0]        checker_source,
  input wire logic [2:0]        active_mode,
  input wire media_type         active_media,
  input wire logic              state_machine_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Write strobe and the fields it carries
  wire       wr_take = psel && penable && pwrite;
  wire [7:0] pw_gap  = pwdata[7:0];
  wire [2:0] pw_src  = pwdata[2:0];
  wire       pw_rst  = pwdata[15];

  // Age since reset; strap sync needs a few edges to settle
  logic [2:0] age_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  wire settled = (age_reg == 3'h7) && !state_machine_reset;

  chk_gap_store: assert property (wr_take && paddr == 12'h04c |=>
    inter_frame_gap == $past(pw_gap)) else $error("gap not stored");
  chk_gap_min: assert property (gen_frame_done |=> !gen_gap_open)
    else $error("gap open too soon");
  chk_gap_pulse: assert property (gen_gap_open |=> !gen_gap_open)
    else $error("gap open too long");
  chk_src_store: assert property (wr_take && paddr == 12'h048 |=>
    checker_source == $past(pw_src)) else $error("source not stored");
  chk_srst_start: assert property (wr_take && paddr == 12'h050 &&
    pw_rst |=> state_machine_reset) else $error("reset not at once");
  chk_srst_end: assert property ($rose(state_machine_reset) |->
    state_machine_reset [*2] ##[1:3] !state_machine_reset)
    else $error("reset did not end");
  chk_mode_defer: assert property (wr_take && paddr == 12'h050 |=>
    $stable(active_mode)) else $error("mode applied early");
  chk_media_sgmii: assert property (settled && $stable(active_mode) &&
    active_mode == MODE_S_COPPER |-> active_media == MEDIA_S_COP)
    else $error("media decode wrong");
  chk_media_fx: assert property (settled && $stable(active_mode) &&
    active_mode == MODE_Q_100FX |->
    active_media inside {MEDIA_Q_FX, MEDIA_Q_AUTO})
    else $error("fx media decode wrong");
  chk_bad_addr: assert property (psel && penable && paddr == 12'h100
    |-> pslverr) else $error("no error on unmapped");

  // Main scenarios reached
  cov_srst: cover property ($fell(state_machine_reset));
  cov_gap: cover property (gen_gap_open);
  cov_err: cover property (pslverr);
endmodule : crc_check_props

bind crc_checker_and_mode_control crc_check_props u_props (
  .core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gen_frame_done(gen_frame_done), .gen_gap_open(gen_gap_open),
  .inter_frame_gap(inter_frame_gap), .checker_source(checker_source),
  .active_mode(active_mode), .active_media(active_media),
  .state_machine_reset(state_machine_reset));

/* test/rx_path_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Receive path model: packet-end strobes of three paths
// ----------------------------------------------------------------------
module rx_path_model (
  input  wire logic  core_clk,
  output logic [2:0] pkt_end,
  output logic [2:0] crc_bad
);
  initial begin
    pkt_end = 3'h0;
    crc_bad = 3'h5;
  end

  // One packet; the flag is inverted after, so stale values never match
  task automatic send(input int p, input logic bad);
    @(posedge core_clk);
    pkt_end[p] <= 1'b1;
    crc_bad    <= {3{bad}};
    @(posedge core_clk);
    pkt_end    <= 3'h0;
    crc_bad    <= {3{~bad}};
  endtask : send
endmodule : rx_path_model

/* test/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) \
  begin \
    comparisons++; \
    if ((a) !== (e)) begin \
      err_total++; \
      $display("unexpected %s expected %0h seen %0h", n, e, a); \
    end \
  end
// ----------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------
module testbench;
  import crc_check_pkg::*;
  logic              core_clk, nrst, ce, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdv;
  logic              pready, pslverr, last_err, irq;
  logic              gen_frame_done, gen_gap_open, state_machine_reset;
  logic [2:0]        mode_strap, checker_source, active_mode;
  logic [2:0]        pkt_end, crc_bad;
  logic [7:0]        inter_frame_gap;
  media_type         active_media;
  logic [31:0]       seed = 32'h00004ead;
  int                err_total, comparisons, pkt, err, src;
  media_type         mtab [5] = '{MEDIA_Q_COP, MEDIA_S_COP, MEDIA_Q_1000X,
                                  MEDIA_Q_FX, MEDIA_Q_AUTO};

  crc_checker_and_mode_control u_dut (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .copper_pkt_end(pkt_end[0]), .copper_crc_bad(crc_bad[0]),
    .sgmii_pkt_end(pkt_end[1]), .sgmii_crc_bad(crc_bad[1]),
    .qsgmii_pkt_end(pkt_end[2]), .qsgmii_crc_bad(crc_bad[2]),
    .mode_strap(mode_strap), .gen_frame_done(gen_frame_done),
    .gen_gap_open(gen_gap_open), .inter_frame_gap(inter_frame_gap),
    .checker_source(checker_source), .active_mode(active_mode),
    .active_media(active_media),
    .state_machine_reset(state_machine_reset), .irq(irq));
  rx_path_model u_rx (.core_clk(core_clk), .pkt_end(pkt_end),
    .crc_bad(crc_bad));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdv      = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Packet on path p; model counts only the selected path, saturating
  task automatic pkt_send(input int p, input logic bad);
    u_rx.send(p, bad);
    if (src != 0 && p == src / 2 - 1) begin
      pkt = (pkt < 255) ? pkt + 1 : 255;
      if (bad) err = (err < 255) ? err + 1 : 255;
    end
  endtask : pkt_send

  task automatic chk_counts();
    rd(12'h044);
    `CHK("counts", {pkt[7:0], err[7:0]}, rdv[15:0])
  endtask : chk_counts

  // Gap from the sampled frame-done edge to the open pulse
  task automatic gap_run(input int g);
    int n;
    wr(12'h04c, g);
    #1;
    `CHK("gap reg", g[7:0], inter_frame_gap)
    @(posedge core_clk);
    gen_frame_done <= 1'b1;
    @(posedge core_clk);
    gen_frame_done <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (gen_gap_open !== 1'b1 && n < 300);
    `CHK("gap length", g + 1, n)
  endtask : gap_run

  // Watchdog: whole run is under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    gen_frame_done = 1'b0;
    mode_strap = rnd() % 4;
    nrst = 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Reset values and strap load
    `CHK("strap mode", mode_strap, active_mode)
    rd(12'h050);
    `CHK("general", 32'h200 | mode_strap, rdv)
    rd(12'h04c);
    `CHK("gap reset", 32'h0b, rdv)
    chk_counts();
    rd(12'h048);
    `CHK("checker reset", 32'h0, rdv)
    $display("test reset done");
    // Each source: clear, enable, random traffic on all paths
    for (int s = 2; s <= 6; s += 2) begin
      src = s;
      wr(12'h048, 32'h10 | s);
      pkt = 0;
      err = 0;
      #1;
      `CHK("source", s[2:0], checker_source)
      rd(12'h048);
      `CHK("clear bit", 1'b0, rdv[4])
      chk_counts();
      for (int i = 0; i < 12; i++) pkt_send(rnd() % 3, rnd() % 2);
      chk_counts();
    end
    wr(12'h048, 32'h0);
    src = 0;
    pkt = 0;
    err = 0;
    chk_counts();
    $display("test sources done");
    // Saturation, then a write to the read-only counts
    src = 2;
    wr(12'h048, 32'h2);
    for (int i = 0; i < 260; i++) pkt_send(0, 1'b1);
    chk_counts();
    wr(12'h044, 32'h0);
    chk_counts();
    wr(12'h048, 32'h12);
    pkt = 0;
    err = 0;
    chk_counts();
    // Clock enable low: a packet must not be counted
    ce <= 1'b0;
    u_rx.send(0, 1'b1);
    ce <= 1'b1;
    chk_counts();
    $display("test saturate done");
    gap_run(0);
    gap_run(rnd() % 40);
    $display("test gap done");
    // Modes: held until software reset, then applied and decoded
    for (int m = 0; m < 5; m++) begin
      logic [2:0] gm;
      logic [2:0] old;
      logic [31:0] mv;
      gm  = (m == 4) ? 3'h3 : m[2:0];
      mv  = ((m == 4) ? 32'h40 : 32'h0) | gm;
      old = active_mode;
      wr(12'h050, mv);
      repeat (4) @(posedge core_clk);
      `CHK("mode held", old, active_mode)
      // software follows the change with a reset
      wr(12'h050, 32'h8000 | mv);
      for (int k = 0; k < 8 && (k == 0 || rdv[15]); k++) rd(12'h050);
      `CHK("reset self clear", 1'b0, rdv[15])
      `CHK("mode applied", gm, active_mode)
      `CHK("media", mtab[m], active_media)
    end
    $display("test mode done");
    // Interrupt: raise, clear, mask
    src = 2;
    wr(12'h05c, 32'h7);
    wr(12'h058, 32'h1);
    #1;
    `CHK("irq idle", 1'b0, irq)
    pkt_send(0, 1'b0);
    repeat (2) @(posedge core_clk);
    `CHK("irq raised", 1'b1, irq)
    wr(12'h05c, 32'h1);
    @(posedge core_clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(12'h058, 32'h0);
    pkt_send(0, 1'b1);
    repeat (2) @(posedge core_clk);
    `CHK("irq masked", 1'b0, irq)
    rd(12'h054);
    `CHK("irq status", 3'h3, rdv[2:0])
    rd(12'h100);
    `CHK("unmapped err", 1'b1, last_err)
    `CHK("unmapped data", 32'h0, rdv)
    $display("test irq and map done");
    report_and_stop();
  end
endmodule : testbench
